// ### src/fault_pkg.sv
package fault_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_PERIOD_PS = 10000;
   localparam int HOLD_TIME_NS = 40000;
   localparam int HOLD_CYCLES = (HOLD_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int SOFT_START_MIN_US = 512;
   localparam int SOFT_START_CYCLES =
      (SOFT_START_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CC_OVP_MAX_NS = 60;
   localparam int CC_OVP_MAX_CYCLES = (CC_OVP_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int TMR_W = 16;
   localparam int SYNC_W = 6;

   // ==========================================================
   // Control byte layout (write register)
   // ==========================================================
   localparam int CTRL_VCONN_DIS = 7;
   localparam int CTRL_VBUS_DIS = 6;
   localparam int CTRL_PM_HI = 5;
   localparam int CTRL_PM_LO = 4;
   localparam int CTRL_GATE_CONS = 3;
   localparam int CTRL_GATE_PROV = 2;
   localparam int CTRL_VSEL_HI = 1;
   localparam int CTRL_VSEL_LO = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Recovery word: mask off the power-mode field, compare the rest
   localparam logic [7:0] RECOVERY_MASK = 8'hcf;
   localparam logic [7:0] RECOVERY_VALUE = 8'h08;

   // VCONN switch select field
   localparam logic [1:0] VSEL_CC1 = 2'h1;
   localparam logic [1:0] VSEL_CC2 = 2'h2;

   // ==========================================================
   // Flag byte layout (status register)
   // ==========================================================
   localparam int FLAG_DEV_ID = 7;
   localparam int FLAG_OVP_CC = 4;
   localparam int FLAG_OTP = 3;
   localparam int FLAG_OVP_VBUS = 2;
   localparam int FLAG_OCP_VBUS = 1;
   localparam int FLAG_OCP_VCONN = 0;
   // Device variant bit, arbitrary neutral value
   localparam logic DEVICE_VARIANT = 1'b0;

   // Power mode field {high, low}
   typedef enum logic [1:0] {
      PM_HIBERNATE = 2'b00,
      PM_NORMAL = 2'b01,
      PM_LOW_POWER = 2'b10,
      PM_UNUSED = 2'b11
   } power_mode_t;

   // Overcurrent supervision states
   typedef enum logic [1:0] {
      SUP_RUN = 2'b00,
      SUP_HOLD = 2'b01,
      SUP_WAIT_RECOVERY = 2'b10
   } sup_state_t;
endpackage

// ### src/timer_if.sv
`timescale 1ns/1ps
interface timer_if;
   logic start;
   logic [fault_pkg::TMR_W-1:0] load;
   logic running;
   logic expired;
   modport owner (output start, output load, input running, input expired);
   modport counter (input start, input load, output running, output expired);
endinterface

// ### src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;

   // Two stages; only the second stage is visible outside
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= '0;
         sync_o <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end
endmodule

// ### src/down_timer.sv
`timescale 1ns/1ps
module down_timer (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   timer_if.counter tmr
);
   import fault_pkg::*;

   logic [TMR_W-1:0] cnt_reg;
   logic running_reg;
   logic expired_reg;

   assign tmr.running = running_reg;
   assign tmr.expired = expired_reg;

   // A start reloads even while running, so a restart is always full length
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= '0;
         running_reg <= 1'b0;
         expired_reg <= 1'b0;
      end else begin
         expired_reg <= 1'b0;
         if (tmr.start) begin
            cnt_reg <= tmr.load - 1'b1;
            running_reg <= 1'b1;
         end else if (running_reg) begin
            if (cnt_reg == '0) begin
               running_reg <= 1'b0;
               expired_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 1'b1;
            end
         end
      end
   end
endmodule

// ### src/port_fault_supervisor.sv
`timescale 1ns/1ps
module port_fault_supervisor #(
   parameter int SOFT_START_LEN = fault_pkg::SOFT_START_CYCLES
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Control byte written by the serial host block (same clock)
   input wire logic ctrl_wr_i,
   input wire logic [7:0] ctrl_byte_i,
   // Analog comparators, asynchronous to clk_i
   input wire logic bus_overcurrent_i,
   input wire logic overcurrent_fault_signal_i,
   input wire logic cc1_overvoltage_i,
   input wire logic cc2_overvoltage_i,
   input wire logic bus_overvoltage_i,
   input wire logic over_temperature_i,
   input wire logic connector_bus_voltage_i,
   // Power path controls
   output logic cc1_switch_o,
   output logic cc2_switch_o,
   output logic vconn_switch_one_o,
   output logic vconn_switch_two_o,
   output logic gate_provider_o,
   output logic gate_consumer_o,
   output logic bus_discharge_o,
   output logic vconn_discharge_cc1_o,
   output logic vconn_discharge_cc2_o,
   output logic current_sense_en_o,
   output logic bus_ocp_en_o,
   output logic vconn_trip_raised_o,
   // Open-drain fault flag
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe_o,
   // Readable status bytes
   output logic [7:0] ack_byte_o,
   output logic [7:0] flag_byte_o,
   output fault_pkg::power_mode_t power_mode_o
);
   import fault_pkg::*;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync_in;
   logic bus_ocp_s;
   logic vconn_ocp_s;
   logic cc1_ovp_s;
   logic cc2_ovp_s;
   logic bus_ovp_s;
   logic otp_s;
   logic bus_present_s;

   assign async_in = {over_temperature_i, bus_overvoltage_i,
                      cc2_overvoltage_i, cc1_overvoltage_i,
                      overcurrent_fault_signal_i, bus_overcurrent_i};

   sync2 #(.W(SYNC_W)) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(async_in),
      .sync_o(sync_in)
   );

   // Bus presence is slow and separate; a one-bit synchroniser suffices
   sync2 #(.W(1)) u_sync_present (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(connector_bus_voltage_i),
      .sync_o(bus_present_s)
   );

   assign bus_ocp_s = sync_in[0];
   assign vconn_ocp_s = sync_in[1];
   assign cc1_ovp_s = sync_in[2];
   assign cc2_ovp_s = sync_in[3];
   assign bus_ovp_s = sync_in[4];
   assign otp_s = sync_in[5];

   // ==========================================================
   // Timers
   // ==========================================================
   timer_if hold_tmr ();
   timer_if soft_tmr ();

   down_timer u_hold_timer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .tmr(hold_tmr.counter)
   );

   down_timer u_soft_timer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .tmr(soft_tmr.counter)
   );

   // ==========================================================
   // Control register and supervision state
   // ==========================================================
   logic [7:0] ctrl_reg;
   sup_state_t state_reg;
   sup_state_t state_next;
   logic bus_src_reg;
   logic vconn_src_reg;
   logic ocp_prev_reg;
   logic last_cc2_reg;
   logic vconn_on_prev_reg;
   power_mode_t mode;
   logic mode_normal;
   logic bus_ocp_det;
   logic vconn_ocp_det;
   logic ocp_any;
   logic ocp_edge;
   logic recovery_hit;

   // Mode field decode of the control register, shared by the mode signal and the acknowledge byte
   function automatic power_mode_t mode_of(input logic [7:0] b);
      return power_mode_t'(b[CTRL_PM_HI:CTRL_PM_LO]);
   endfunction

   assign mode = mode_of(ctrl_reg);
   assign mode_normal = (mode == PM_NORMAL);
   assign bus_ocp_det = bus_ocp_s & mode_normal;
   // Cable-power comparator already trips at the selected level
   assign vconn_ocp_det = vconn_ocp_s & (vconn_switch_one_o |
                                         vconn_switch_two_o);
   assign ocp_any = bus_ocp_det | vconn_ocp_det;
   assign ocp_edge = ocp_any & ~ocp_prev_reg;
   assign recovery_hit = ctrl_wr_i &
      ((ctrl_byte_i & RECOVERY_MASK) == RECOVERY_VALUE);

   // Hold timer starts on the detection edge only
   assign hold_tmr.start = (state_reg == SUP_RUN) & ocp_edge;
   assign hold_tmr.load = TMR_W'(HOLD_CYCLES);

   // Edge memory for overcurrent detection
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ocp_prev_reg <= 1'b0;
      end else begin
         ocp_prev_reg <= ocp_any;
      end
   end

   // Supervision state transitions
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SUP_RUN: begin
            if (ocp_edge) begin
               state_next = SUP_HOLD;
            end
         end
         SUP_HOLD: begin
            // Recovery words are simply dropped here
            if (hold_tmr.expired) begin
               state_next = SUP_WAIT_RECOVERY;
            end
         end
         SUP_WAIT_RECOVERY: begin
            if (recovery_hit) begin
               state_next = SUP_RUN;
            end
         end
         default: begin
            state_next = SUP_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= SUP_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // Host control byte; in shutdown only a recovery word written after the hold is accepted
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= CTRL_RESET;
      end else if (state_reg == SUP_RUN && ocp_edge) begin
         // Drop switch and gate requests so nothing recloses on restart
         ctrl_reg <= {2'b00, ctrl_reg[CTRL_PM_HI:CTRL_PM_LO], 4'h0};
      end else if (state_reg == SUP_WAIT_RECOVERY && recovery_hit) begin
         ctrl_reg <= {2'b00, ctrl_byte_i[CTRL_PM_HI:CTRL_PM_LO], 4'h0};
      end else if (state_reg == SUP_RUN && ctrl_wr_i) begin
         ctrl_reg <= ctrl_byte_i;
      end
   end

   // Overcurrent source flags: set on the event, cleared by recovery
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_src_reg <= 1'b0;
         vconn_src_reg <= 1'b0;
      end else if (state_reg == SUP_RUN && ocp_edge) begin
         bus_src_reg <= bus_ocp_det;
         vconn_src_reg <= vconn_ocp_det;
      end else if (state_reg == SUP_WAIT_RECOVERY && recovery_hit) begin
         bus_src_reg <= 1'b0;
         vconn_src_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Cable-power soft start and discharge steering
   // ==========================================================
   logic vsel1_next;
   logic vsel2_next;
   logic vconn_on_next;

   assign soft_tmr.start = vconn_on_next & ~vconn_on_prev_reg;
   assign soft_tmr.load = TMR_W'(SOFT_START_LEN);

   // Remember which CC pin last carried cable power
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_cc2_reg <= 1'b0;
         vconn_on_prev_reg <= 1'b0;
      end else begin
         vconn_on_prev_reg <= vconn_on_next;
         if (vsel1_next) begin
            last_cc2_reg <= 1'b0;
         end else if (vsel2_next) begin
            last_cc2_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Output next values
   // ==========================================================
   logic run;
   logic otp_block;
   logic cc1_next;
   logic cc2_next;
   logic prov_next;
   logic cons_next;
   logic bus_dis_next;
   logic vconn_dis_next;
   logic flag_low_next;

   assign run = (state_reg == SUP_RUN) & ~ocp_edge;
   assign otp_block = otp_s;

   always_comb begin
      vsel1_next = run & ~otp_block &
         (ctrl_reg[CTRL_VSEL_HI:CTRL_VSEL_LO] == VSEL_CC1);
      vsel2_next = run & ~otp_block &
         (ctrl_reg[CTRL_VSEL_HI:CTRL_VSEL_LO] == VSEL_CC2);
      vconn_on_next = vsel1_next | vsel2_next;
      // CC paths open only in hold, over-temperature or own overvoltage
      cc1_next = (state_next != SUP_HOLD) & ~otp_block & ~cc1_ovp_s;
      cc2_next = (state_next != SUP_HOLD) & ~otp_block & ~cc2_ovp_s;
      prov_next = run & ~otp_block & ctrl_reg[CTRL_GATE_PROV];
      cons_next = run & ~otp_block & ctrl_reg[CTRL_GATE_CONS];
      // Bus discharge from command, plus forced during a bus shutdown
      bus_dis_next = ctrl_reg[CTRL_VBUS_DIS] |
         ((state_reg != SUP_RUN) & bus_src_reg) |
         (ocp_edge & bus_ocp_det & (state_reg == SUP_RUN));
      vconn_dis_next = (ctrl_reg[CTRL_VCONN_DIS] | bus_dis_next &
         ~ctrl_reg[CTRL_VBUS_DIS]) & ~vconn_on_next;
      // Flag meaning depends on power mode
      if (mode_normal) begin
         flag_low_next = (state_next != SUP_RUN) | cc1_ovp_s | cc2_ovp_s |
            otp_block | bus_ovp_s;
      end else begin
         flag_low_next = bus_present_s | (state_next != SUP_RUN);
      end
   end

   // ==========================================================
   // Registered outputs
   // ==========================================================
   // All outputs leave from flops so pins never glitch on decode hazards
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cc1_switch_o <= 1'b0;
         cc2_switch_o <= 1'b0;
         vconn_switch_one_o <= 1'b0;
         vconn_switch_two_o <= 1'b0;
         gate_provider_o <= 1'b0;
         gate_consumer_o <= 1'b0;
         bus_discharge_o <= 1'b0;
         vconn_discharge_cc1_o <= 1'b0;
         vconn_discharge_cc2_o <= 1'b0;
         current_sense_en_o <= 1'b0;
         bus_ocp_en_o <= 1'b0;
         vconn_trip_raised_o <= 1'b0;
         fault_flag_n_oe_o <= 1'b0;
      end else begin
         cc1_switch_o <= cc1_next;
         cc2_switch_o <= cc2_next;
         vconn_switch_one_o <= vsel1_next;
         vconn_switch_two_o <= vsel2_next;
         gate_provider_o <= prov_next;
         gate_consumer_o <= cons_next;
         bus_discharge_o <= bus_dis_next;
         vconn_discharge_cc1_o <= vconn_dis_next & ~last_cc2_reg;
         vconn_discharge_cc2_o <= vconn_dis_next & last_cc2_reg;
         current_sense_en_o <= mode_normal;
         bus_ocp_en_o <= mode_normal;
         // Raised level while starting up, normal once the window ends
         vconn_trip_raised_o <= soft_tmr.start |
            (soft_tmr.running & vconn_on_next);
         fault_flag_n_oe_o <= flag_low_next;
      end
   end

   // Open-drain pin only ever pulls low
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fault_flag_n_o <= 1'b0;
      end else begin
         fault_flag_n_o <= 1'b0;
      end
   end

   // Status bytes; acknowledges mirror driven state so shutdown clears the switch and gate bits
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_byte_o <= 8'h00;
         flag_byte_o <= 8'h00;
         power_mode_o <= PM_HIBERNATE;
      end else begin
         ack_byte_o <= {vconn_dis_next, bus_dis_next, mode_of(ctrl_reg),
                        cons_next, prov_next, vsel2_next, vsel1_next};
         flag_byte_o <= 8'h00;
         flag_byte_o[FLAG_DEV_ID] <= DEVICE_VARIANT;
         flag_byte_o[FLAG_OVP_CC] <= cc1_ovp_s | cc2_ovp_s;
         flag_byte_o[FLAG_OTP] <= otp_block;
         flag_byte_o[FLAG_OVP_VBUS] <= bus_ovp_s;
         // Source bits fall with the recovery word, in step with the flag
         flag_byte_o[FLAG_OCP_VBUS] <= (state_next != SUP_RUN) &
            (bus_src_reg | (ocp_edge & bus_ocp_det &
            (state_reg == SUP_RUN)));
         flag_byte_o[FLAG_OCP_VCONN] <= (state_next != SUP_RUN) &
            (vconn_src_reg | (ocp_edge & vconn_ocp_det &
            (state_reg == SUP_RUN)));
         power_mode_o <= mode;
      end
   end
endmodule

// ### testbench/fault_supervisor_assertions.sv
`timescale 1ns/1ps
module fault_supervisor_assertions #(
   parameter int SOFT_START_LEN = 20
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ctrl_wr_i,
   input wire logic cc1_overvoltage_i,
   input wire logic over_temperature_i,
   input wire logic cc1_switch_o,
   input wire logic cc2_switch_o,
   input wire logic vconn_switch_one_o,
   input wire logic vconn_switch_two_o,
   input wire logic gate_provider_o,
   input wire logic gate_consumer_o,
   input wire logic bus_discharge_o,
   input wire logic vconn_discharge_cc1_o,
   input wire logic vconn_discharge_cc2_o,
   input wire logic current_sense_en_o,
   input wire logic bus_ocp_en_o,
   input wire logic vconn_trip_raised_o,
   input wire logic fault_flag_n_o,
   input wire logic fault_flag_n_oe_o,
   input wire logic [7:0] ack_byte_o,
   input wire logic [7:0] flag_byte_o,
   input wire fault_pkg::power_mode_t power_mode_o
);
   import fault_pkg::*;
   localparam int HOLD_LO = HOLD_CYCLES - 5;
   localparam int HOLD_HI = HOLD_CYCLES + 5;
   localparam int SS_LO = SOFT_START_LEN - 1;
   localparam int SS_HI = SOFT_START_LEN + 1;
   logic ocp_any;
   logic sw_any;
   logic [15:0] hold_cnt;
   logic [15:0] ss_cnt;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // ======================================================
   // Helper counters
   // ======================================================
   assign ocp_any = |flag_byte_o[1:0];
   assign sw_any = vconn_switch_one_o | vconn_switch_two_o;

   // Cycles with CC open since the overcurrent flag rose
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i || !ocp_any) begin
         hold_cnt <= 16'h0;
      end else if (!cc1_switch_o) begin
         hold_cnt <= hold_cnt + 16'h1;
      end
   end

   // Cycles at raised trip level; restarts when both VCONN switches open
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i || !sw_any) begin
         ss_cnt <= 16'h0;
      end else if (vconn_trip_raised_o) begin
         ss_cnt <= ss_cnt + 16'h1;
      end
   end

   // ======================================================
   // Properties
   // ======================================================
   sequence ocp_rise;
      $rose(ocp_any);
   endsequence
   sequence paths_off;
      !sw_any && !gate_provider_o && !gate_consumer_o &&
         !cc1_switch_o && !cc2_switch_o;
   endsequence

   sense_mode_a: assert property (
      current_sense_en_o || bus_ocp_en_o |-> power_mode_o == PM_NORMAL)
      else $error("sense or ocp enable outside normal mode");
   ocp_shut_a: assert property (ocp_rise |-> paths_off)
      else $error("paths not shut on overcurrent");
   bus_ocp_a: assert property ($rose(flag_byte_o[1]) |->
      bus_discharge_o && (vconn_discharge_cc1_o || vconn_discharge_cc2_o)
      && ack_byte_o[3:0] == 4'h0)
      else $error("bus overcurrent side effects missing");
   hold_time_a: assert property (
      ocp_any && $rose(cc1_switch_o) |->
      hold_cnt >= HOLD_LO && hold_cnt <= HOLD_HI)
      else $error("alarm hold length wrong");
   after_hold_a: assert property (
      ocp_any && cc1_switch_o |-> !sw_any && !gate_provider_o &&
      !gate_consumer_o)
      else $error("power paths on while waiting recovery");
   flag_held_a: assert property (
      ocp_any |-> fault_flag_n_oe_o && !fault_flag_n_o)
      else $error("flag released before recovery");
   early_word_a: assert property (
      ctrl_wr_i && ocp_any && hold_cnt > 0 && hold_cnt < 3900 |=>
      ocp_any && !cc1_switch_o)
      else $error("write accepted during alarm hold");
   dis_lock_a: assert property (
      vconn_discharge_cc1_o || vconn_discharge_cc2_o |-> !sw_any)
      else $error("cable discharge with switch closed");
   cc_ovp_a: assert property (
      $rose(cc1_overvoltage_i) && power_mode_o == PM_NORMAL |->
      ##[1:4] (!cc1_switch_o && fault_flag_n_oe_o))
      else $error("cc line not isolated");
   cc_clear_a: assert property (
      $fell(cc1_overvoltage_i) && !over_temperature_i && !ocp_any |->
      ##[1:4] cc1_switch_o)
      else $error("cc line not released");
   otp_shut_a: assert property (
      $rose(over_temperature_i) |-> ##[1:4] paths_off)
      else $error("paths not shut on over temperature");
   soft_start_a: assert property (
      $fell(vconn_trip_raised_o) && sw_any |->
      ss_cnt >= SS_LO && ss_cnt <= SS_HI)
      else $error("soft start length wrong");
endmodule

bind port_fault_supervisor fault_supervisor_assertions #(
   .SOFT_START_LEN(SOFT_START_LEN)
) chk (.clk_i, .sys_rst_i, .ctrl_wr_i, .cc1_overvoltage_i,
   .over_temperature_i, .cc1_switch_o, .cc2_switch_o, .vconn_switch_one_o,
   .vconn_switch_two_o, .gate_provider_o, .gate_consumer_o,
   .bus_discharge_o, .vconn_discharge_cc1_o, .vconn_discharge_cc2_o,
   .current_sense_en_o, .bus_ocp_en_o, .vconn_trip_raised_o,
   .fault_flag_n_o, .fault_flag_n_oe_o, .ack_byte_o, .flag_byte_o,
   .power_mode_o);

// ### testbench/pd_host_model.sv
`timescale 1ns/1ps
module pd_host_model (
   input wire logic clk_i,
   output logic ctrl_wr_o,
   output logic [7:0] ctrl_byte_o
);
   import fault_pkg::*;

   // ======================================================
   // Control byte writes
   // ======================================================
   initial begin
      ctrl_wr_o = 1'b0;
      ctrl_byte_o = 8'h00;
   end

   // One-cycle write; idle byte is scrambled so a stale value never helps
   task put(input logic [7:0] b);
      @(negedge clk_i);
      ctrl_wr_o <= 1'b1;
      ctrl_byte_o <= b;
      @(negedge clk_i);
      ctrl_wr_o <= 1'b0;
      ctrl_byte_o <= ~b;
   endtask

   // Waits out the alarm hold before restarting
   task recover(input logic [1:0] pm);
      repeat (HOLD_CYCLES + 8) @(negedge clk_i);
      put({2'b00, pm, 4'h8});
   endtask
endmodule

// ### testbench/port_fault_supervisor_bench.sv
`timescale 1ns/1ps
module port_fault_supervisor_bench;
   import fault_pkg::*;
   // Short soft start keeps the run brief
   localparam int SS = 20;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ctrl_wr_i;
   logic [7:0] ctrl_byte_i;
   logic bus_overcurrent_i = 1'b0;
   logic overcurrent_fault_signal_i = 1'b0;
   logic cc1_overvoltage_i = 1'b0;
   logic cc2_overvoltage_i = 1'b0;
   logic bus_overvoltage_i = 1'b0;
   logic over_temperature_i = 1'b0;
   logic connector_bus_voltage_i = 1'b1;
   logic cc1_switch_o, cc2_switch_o, vconn_switch_one_o, vconn_switch_two_o;
   logic gate_provider_o, gate_consumer_o, bus_discharge_o;
   logic vconn_discharge_cc1_o, vconn_discharge_cc2_o, current_sense_en_o;
   logic bus_ocp_en_o, vconn_trip_raised_o, fault_flag_n_o;
   logic fault_flag_n_oe_o;
   logic [7:0] ack_byte_o;
   logic [7:0] flag_byte_o;
   power_mode_t power_mode_o;
   int n_fail = 0;
   int total_checks = 0;

   // ======================================================
   // Clock, host and device
   // ======================================================
   always #5 clk_i = ~clk_i;

   pd_host_model host (.clk_i, .ctrl_wr_o(ctrl_wr_i),
      .ctrl_byte_o(ctrl_byte_i));

   port_fault_supervisor #(.SOFT_START_LEN(SS)) dut (.clk_i, .sys_rst_i,
      .ctrl_wr_i, .ctrl_byte_i, .bus_overcurrent_i,
      .overcurrent_fault_signal_i, .cc1_overvoltage_i, .cc2_overvoltage_i,
      .bus_overvoltage_i, .over_temperature_i, .connector_bus_voltage_i,
      .cc1_switch_o, .cc2_switch_o, .vconn_switch_one_o, .vconn_switch_two_o,
      .gate_provider_o, .gate_consumer_o, .bus_discharge_o,
      .vconn_discharge_cc1_o, .vconn_discharge_cc2_o, .current_sense_en_o,
      .bus_ocp_en_o, .vconn_trip_raised_o, .fault_flag_n_o,
      .fault_flag_n_oe_o, .ack_byte_o, .flag_byte_o, .power_mode_o);

   // ======================================================
   // Shared tasks
   // ======================================================
   task results();
      if (n_fail == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task wr(input logic [7:0] b);
      host.put(b);
      cyc(1);
   endtask

   // Bounded wait for the CC lines to reclose after the hold
   task wait_cc();
      int i;
      for (i = 0; i < 5000 && cc1_switch_o !== 1'b1; i++) cyc(1);
      if (i == 5000) begin
         n_fail++;
         results();
      end
   endtask

   // ======================================================
   // Scenarios
   // ======================================================
   task t_hib();
      cyc(4);
      chk1(fault_flag_n_oe_o, 1'b1);
      chk1(current_sense_en_o, 1'b0);
      bus_overcurrent_i = 1'b1;
      cyc(5);
      chk8(flag_byte_o & 8'h02, 8'h00);
      chk1(cc1_switch_o, 1'b1);
      bus_overcurrent_i = 1'b0;
      connector_bus_voltage_i = 1'b0;
      cyc(4);
      chk1(fault_flag_n_oe_o, 1'b0);
   endtask

   task t_normal();
      wr(8'h1d);
      chk8(ack_byte_o, 8'h1d);
      chk1(current_sense_en_o, 1'b1);
      chk1(bus_ocp_en_o, 1'b1);
      chk1(vconn_trip_raised_o, 1'b1);
      cyc(SS - 3);
      chk1(vconn_trip_raised_o, 1'b1);
      cyc(10);
      chk1(vconn_trip_raised_o, 1'b0);
   endtask

   task t_bus_ocp();
      bus_overcurrent_i = 1'b1;
      cyc(4);
      chk1(gate_provider_o | vconn_switch_one_o | cc1_switch_o, 1'b0);
      chk1(bus_discharge_o, 1'b1);
      chk8(flag_byte_o & 8'h03, 8'h02);
      chk8(ack_byte_o & 8'h0f, 8'h00);
      chk1(fault_flag_n_oe_o, 1'b1);
      bus_overcurrent_i = 1'b0;
      wr(8'h18);
      chk8(flag_byte_o & 8'h03, 8'h02);
      chk1(cc1_switch_o, 1'b0);
      wait_cc();
      chk1(gate_consumer_o | vconn_switch_one_o, 1'b0);
      chk1(fault_flag_n_oe_o, 1'b1);
      wr(8'h19);
      chk8(flag_byte_o & 8'h03, 8'h02);
      host.recover(2'b01);
      cyc(1);
      chk8(flag_byte_o & 8'h03, 8'h00);
      chk8(ack_byte_o, 8'h10);
      chk1(fault_flag_n_oe_o, 1'b0);
   endtask

   task t_vconn_ocp();
      wr(8'h1e);
      chk1(vconn_switch_two_o, 1'b1);
      overcurrent_fault_signal_i = 1'b1;
      cyc(4);
      chk8(flag_byte_o & 8'h03, 8'h01);
      chk1(vconn_switch_two_o | cc2_switch_o, 1'b0);
      overcurrent_fault_signal_i = 1'b0;
      wait_cc();
      host.recover(2'b10);
      cyc(1);
      chk8({6'h0, power_mode_o}, 8'h02);
      chk1(current_sense_en_o, 1'b0);
   endtask

   task t_discharge();
      wr(8'h90);
      chk8({6'h0, vconn_discharge_cc2_o, vconn_discharge_cc1_o},
         8'h02);
      wr(8'h92);
      chk8({6'h0, vconn_discharge_cc2_o, vconn_discharge_cc1_o},
         8'h00);
      wr(8'h91);
      wr(8'h90);
      chk8({6'h0, vconn_discharge_cc2_o, vconn_discharge_cc1_o},
         8'h01);
      wr(8'h50);
      chk1(bus_discharge_o, 1'b1);
      wr(8'h10);
      chk1(bus_discharge_o, 1'b0);
   endtask

   task t_cc_ovp();
      cc1_overvoltage_i = 1'b1;
      cyc(4);
      chk8({5'h0, cc2_switch_o, cc1_switch_o, fault_flag_n_oe_o},
         8'h05);
      chk8(flag_byte_o & 8'h10, 8'h10);
      cc1_overvoltage_i = 1'b0;
      cyc(4);
      chk8({5'h0, cc2_switch_o, cc1_switch_o, fault_flag_n_oe_o},
         8'h06);
      cc2_overvoltage_i = 1'b1;
      bus_overvoltage_i = 1'b1;
      cyc(4);
      chk8({5'h0, cc2_switch_o, cc1_switch_o, fault_flag_n_oe_o},
         8'h03);
      chk8(flag_byte_o & 8'h14, 8'h14);
      cc2_overvoltage_i = 1'b0;
      bus_overvoltage_i = 1'b0;
      cyc(4);
      chk1(cc2_switch_o, 1'b1);
   endtask

   task t_otp();
      wr(8'h1d);
      over_temperature_i = 1'b1;
      cyc(4);
      chk1(gate_provider_o | vconn_switch_one_o | cc1_switch_o, 1'b0);
      chk1(fault_flag_n_oe_o, 1'b1);
      chk8(flag_byte_o & 8'h08, 8'h08);
      over_temperature_i = 1'b0;
      cyc(4);
      chk8(flag_byte_o & 8'h08, 8'h00);
      chk1(fault_flag_n_oe_o, 1'b0);
      chk1(gate_provider_o, 1'b1);
   endtask

   // Main sequence
   initial begin
      repeat (3) @(negedge clk_i);
      sys_rst_i = 1'b0;
      t_hib();
      t_normal();
      t_bus_ocp();
      t_vconn_ocp();
      t_discharge();
      t_cc_ovp();
      t_otp();
      results();
   end
endmodule
